// ---- common/irpa_pkg.sv ----
`default_nettype none
package irpa_pkg;
  // Target address on the two-wire bus (arbitrary value)
  localparam logic [6:0] DEV_ADDR = 7'h22;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Register map of the expander
  localparam logic [7:0] INPUT_LEVEL_0 = 8'h00;
  localparam logic [7:0] OUTPUT_LEVEL_0 = 8'h04;
  localparam logic [7:0] OUTPUT_LEVEL_1 = 8'h05;
  localparam logic [7:0] OUTPUT_LEVEL_2 = 8'h06;
  localparam logic [7:0] OUTPUT_STAGE_TYPE = 8'h5C;
  localparam logic [7:0] DRIVE_GROUP_BASE = 8'h40;
  localparam logic [7:0] EDGE_GROUP_BASE = 8'h60;
  localparam logic [2:0] SIX_GROUP_LAST = 3'h5;
  localparam logic [1:0] TRIPLE_LAST = 2'h2;

  // Bit counter values inside one byte slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;
  localparam logic [3:0] BIT_MSB = 4'h7;

  // Controller timing
  localparam int SYS_CLK_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * SYS_CLK_NS);
  localparam logic [7:0] QUARTER_LOAD = 8'(QUARTER_CYC - 1);

  // Controller registers: byte addresses on APB, then command and status bit positions and the last bit index
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] TXDATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0C;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_WRITE = 2;
  localparam int CMD_READ = 3;
  localparam int CMD_NACK = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_OWNS = 2;
  localparam logic [3:0] LAST_BIT = 4'h8;
endpackage
`default_nettype wire

// ---- common/irpa_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface irpa_if;
  logic mSclOe;
  logic mSdaOe;
  logic tSdaOe;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups: an enabled driver pulls low
  assign scl = !mSclOe;
  assign sda = !(mSdaOe | tSdaOe);
  modport master (output mSclOe, output mSdaOe, input scl, input sda);
  modport target (output tSdaOe, input scl, input sda);
endinterface
`default_nettype wire

// ---- rtl/irpa_target.sv ----
// Decided for this implementation: register access through a pointer, read-data and write-strobe port.
`timescale 1ns/1ns
`default_nettype none
module irpa_target (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic resetPinN,
  irpa_if.target bus,
  input wire logic [7:0] regRdData,
  output logic [7:0] regPtr,
  output logic regWrEn,
  output logic [7:0] regWrAddr,
  output logic [7:0] regWrData,
  output logic intClr,
  output logic [1:0] intClrPort,
  output logic busActive
);

  typedef enum logic [2:0] {
    T_IDLE,
    T_ADDR,
    T_CMD,
    T_WDATA,
    T_RDATA
  } irpa_tstate_t;

  irpa_tstate_t state_q;
  irpa_tstate_t state_d;
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic [1:0] pinPrev_q;
  logic rstMeta_q;
  logic rstSync_q;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic sdaOe_q;
  logic sdaOe_d;
  logic [7:0] ptr_q;
  logic wrEn_q;
  logic [7:0] wrAddr_q;
  logic [7:0] wrData_q;
  logic intClr_q;
  logic [1:0] intClrPort_q;
  logic active_q;

  // Pointer step: six-groups and triples wrap inside themselves
  function automatic logic [7:0] irpa_ptr_next(input logic [7:0] p);
    logic [7:0] n;
    n = p;
    if (p == irpa_pkg::OUTPUT_STAGE_TYPE) begin
      n = p;
    end else if (p[7:3] == irpa_pkg::DRIVE_GROUP_BASE[7:3] ||
                 p[7:3] == irpa_pkg::EDGE_GROUP_BASE[7:3]) begin
      if (p[2:0] >= irpa_pkg::SIX_GROUP_LAST) begin
        n = {p[7:3], 3'h0};
      end else begin
        n = {p[7:3], 3'(p[2:0] + 3'h1)};
      end
    end else begin
      if (p[1:0] >= irpa_pkg::TRIPLE_LAST) begin
        n = {p[7:2], 2'h0};
      end else begin
        n = {p[7:2], 2'(p[1:0] + 2'h1)};
      end
    end
    return n;
  endfunction

  // Pin sampling: scl in bit 1, sda in bit 0
  wire logic [1:0] pinRaw = {bus.scl, bus.sda};
  wire logic localRst = rst | !rstSync_q;
  wire logic sclHigh = pinSync_q[1] & pinPrev_q[1];
  wire logic sclRise = pinSync_q[1] & !pinPrev_q[1];
  wire logic sclFall = !pinSync_q[1] & pinPrev_q[1];
  wire logic startSeen = sclHigh & !pinSync_q[0] & pinPrev_q[0];
  wire logic stopSeen = sclHigh & pinSync_q[0] & !pinPrev_q[0];
  wire logic sdaIn = pinSync_q[0];

  wire logic rxState = (state_q == T_ADDR) | (state_q == T_CMD) | (state_q == T_WDATA);
  wire logic inRead = (state_q == T_RDATA);
  wire logic addrMatch = (shift_q[7:1] == irpa_pkg::DEV_ADDR);
  wire logic readReq = shift_q[0];
  wire logic bitRise = sclRise & (rxState | inRead) & (bitCnt_q < irpa_pkg::BIT_ACK);
  wire logic byteDone = sclFall & rxState & (bitCnt_q == irpa_pkg::BIT_ACK);
  wire logic ackEnd = sclFall & rxState & (bitCnt_q == irpa_pkg::BIT_ACK_END);
  wire logic foreign = byteDone & (state_q == T_ADDR) & !addrMatch;
  wire logic masterAck = sclRise & inRead & (bitCnt_q == irpa_pkg::BIT_ACK);
  wire logic readFirst = ackEnd & (state_q == T_ADDR) & readReq;
  wire logic readNext = sclFall & inRead & (bitCnt_q == irpa_pkg::BIT_ACK_END);
  wire logic loadTx = readFirst | readNext;
  wire logic readBitFall = sclFall & inRead & (bitCnt_q < irpa_pkg::BIT_ACK);
  wire logic readRelease = sclFall & inRead & (bitCnt_q == irpa_pkg::BIT_ACK);
  wire logic [2:0] txSel = 3'(irpa_pkg::BIT_MSB - bitCnt_q);
  wire logic inputGroup = (ptr_q[7:2] == irpa_pkg::INPUT_LEVEL_0[7:2]) &
                          (ptr_q[1:0] <= irpa_pkg::TRIPLE_LAST);
  wire logic [7:0] ptrStep = irpa_ptr_next(ptr_q);

  // First stage of each synchroniser feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta_q <= 2'h3;
      pinSync_q <= 2'h3;
      pinPrev_q <= 2'h3;
      rstMeta_q <= 1'b1;
      rstSync_q <= 1'b1;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      rstMeta_q <= resetPinN;
      rstSync_q <= rstMeta_q;
    end
  end

  // Byte framing state machine
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    if (stopSeen) begin
      state_d = T_IDLE;
    end else if (startSeen) begin
      state_d = T_ADDR;
      bitCnt_d = 4'h0;
    end else if (bitRise) begin
      bitCnt_d = 4'(bitCnt_q + 4'h1);
    end else if (foreign) begin
      state_d = T_IDLE;
    end else if (byteDone) begin
      bitCnt_d = irpa_pkg::BIT_ACK_END;
    end else if (masterAck) begin
      bitCnt_d = irpa_pkg::BIT_ACK_END;
      if (sdaIn) begin
        state_d = T_IDLE;
      end
    end else if (ackEnd | readNext) begin
      bitCnt_d = 4'h0;
      case (state_q)
        T_ADDR: state_d = readReq ? T_RDATA : T_CMD;
        T_CMD: state_d = T_WDATA;
        T_WDATA: state_d = T_WDATA;
        T_RDATA: state_d = T_RDATA;
        default: state_d = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      state_q <= T_IDLE;
      bitCnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      shift_q <= 8'h00;
    end else if (bitRise & rxState) begin
      shift_q <= {shift_q[6:0], sdaIn};
    end
  end

  // Data line drive: acks on receive, data bits on read
  always_comb begin
    sdaOe_d = sdaOe_q;
    if (stopSeen | startSeen) begin
      sdaOe_d = 1'b0;
    end else if (byteDone) begin
      sdaOe_d = !foreign;
    end else if (loadTx) begin
      sdaOe_d = !regRdData[7];
    end else if (ackEnd | readRelease) begin
      sdaOe_d = 1'b0;
    end else if (readBitFall) begin
      sdaOe_d = !tx_q[txSel];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      sdaOe_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      sdaOe_q <= sdaOe_d;
      if (loadTx) begin
        tx_q <= regRdData;
      end
    end
  end

  // Pointer survives START and STOP; only a command byte reloads it
  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      ptr_q <= irpa_pkg::PTR_RESET;
    end else if (byteDone & (state_q == T_CMD)) begin
      ptr_q <= shift_q;
    end else if (ackEnd & (state_q == T_WDATA)) begin
      ptr_q <= ptrStep;
    end else if (masterAck) begin
      ptr_q <= ptrStep;
    end
  end

  // Write strobe to the register file, one cycle
  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      wrEn_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
    end else begin
      wrEn_q <= byteDone & (state_q == T_WDATA);
      if (byteDone & (state_q == T_WDATA)) begin
        wrAddr_q <= ptr_q;
        wrData_q <= shift_q;
      end
    end
  end

  // Interrupt clear at the ack slot of an input port read
  always_ff @(posedge sys_clk) begin
    if (localRst) begin
      intClr_q <= 1'b0;
      intClrPort_q <= 2'h0;
      active_q <= 1'b0;
    end else begin
      intClr_q <= masterAck & inputGroup;
      if (masterAck & inputGroup) begin
        intClrPort_q <= ptr_q[1:0];
      end
      active_q <= (state_d != T_IDLE);
    end
  end

  assign bus.tSdaOe = sdaOe_q;
  assign regPtr = ptr_q;
  assign regWrEn = wrEn_q;
  assign regWrAddr = wrAddr_q;
  assign regWrData = wrData_q;
  assign intClr = intClr_q;
  assign intClrPort = intClrPort_q;
  assign busActive = active_q;

endmodule
`default_nettype wire

// ---- rtl/irpa_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module irpa_master (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  irpa_if.master bus
);

  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP
  } irpa_hstate_t;

  irpa_hstate_t state_q;
  logic [1:0] phase_q;
  logic [7:0] div_q;
  logic [3:0] bitIdx_q;
  logic [8:0] out_q;
  logic [8:0] in_q;
  logic [7:0] txData_q;
  logic sclOe_q;
  logic sdaOe_q;
  logic owns_q;
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire logic setup = psel & !penable;
  wire logic wrDone = psel & penable & pready_q & pwrite;
  wire logic hitCmd = (paddr == irpa_pkg::CMD_OFS);
  wire logic hitTx = (paddr == irpa_pkg::TXDATA_OFS);
  wire logic hitSt = (paddr == irpa_pkg::STATUS_OFS);
  wire logic hitRx = (paddr == irpa_pkg::RXDATA_OFS);
  wire logic mapped = hitCmd | hitTx | hitSt | hitRx;
  wire logic idle = (state_q == H_IDLE);
  wire logic busFree = pinSync_q[1] & pinSync_q[0];
  wire logic cmdWr = wrDone & hitCmd & idle;
  // START only on an idle bus or as a restart of our own transfer
  wire logic goStart = cmdWr & pwdata[irpa_pkg::CMD_START] & (owns_q | busFree);
  wire logic goWrite = cmdWr & !pwdata[irpa_pkg::CMD_START] & pwdata[irpa_pkg::CMD_WRITE];
  wire logic goRead = cmdWr & !pwdata[irpa_pkg::CMD_START] & !pwdata[irpa_pkg::CMD_WRITE] &
                      pwdata[irpa_pkg::CMD_READ];
  wire logic goStop = cmdWr & pwdata[irpa_pkg::CMD_STOP] & !pwdata[irpa_pkg::CMD_START] &
                      !pwdata[irpa_pkg::CMD_WRITE] & !pwdata[irpa_pkg::CMD_READ];
  wire logic tick = !idle & (div_q == 8'h00);
  wire logic [31:0] status = {29'h0, owns_q, in_q[0], !idle};
  wire logic [31:0] rdMux = hitSt ? status :
                            hitRx ? {24'h0, in_q[8:1]} :
                            hitTx ? {24'h0, txData_q} : 32'h0;

  // APB slave: pready high in the access phase, one wait-free answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & !mapped;
      prdata_q <= setup ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txData_q <= 8'h00;
      pinMeta_q <= 2'h3;
      pinSync_q <= 2'h3;
    end else begin
      if (wrDone & hitTx) begin
        txData_q <= pwdata[7:0];
      end
      pinMeta_q <= {bus.scl, bus.sda};
      pinSync_q <= pinMeta_q;
    end
  end

  // Quarter-period divider for the bus clock
  always_ff @(posedge sys_clk) begin
    if (rst | idle | tick) begin
      div_q <= irpa_pkg::QUARTER_LOAD;
    end else begin
      div_q <= 8'(div_q - 8'h01);
    end
  end

  // Bit engine: one operation per command, four phases per step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= H_IDLE;
      phase_q <= 2'h0;
      bitIdx_q <= 4'h0;
      out_q <= 9'h1FF;
      in_q <= 9'h000;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      owns_q <= 1'b0;
    end else if (idle) begin
      phase_q <= 2'h0;
      bitIdx_q <= 4'h0;
      if (goStart) begin
        state_q <= H_START;
      end else if (goWrite) begin
        state_q <= H_BIT;
        out_q <= {txData_q, 1'b1};
      end else if (goRead) begin
        state_q <= H_BIT;
        out_q <= {8'hFF, pwdata[irpa_pkg::CMD_NACK]};
      end else if (goStop) begin
        state_q <= H_STOP;
      end
    end else if (tick) begin
      phase_q <= 2'(phase_q + 2'h1);
      case (state_q)
        H_START: begin
          case (phase_q)
            2'h0: sdaOe_q <= 1'b0;
            2'h1: sclOe_q <= 1'b0;
            2'h2: sdaOe_q <= 1'b1;
            default: begin
              sclOe_q <= 1'b1;
              owns_q <= 1'b1;
              state_q <= H_IDLE;
            end
          endcase
        end
        H_STOP: begin
          case (phase_q)
            2'h0: sdaOe_q <= 1'b1;
            2'h1: sclOe_q <= 1'b0;
            2'h2: sdaOe_q <= 1'b0;
            default: begin
              owns_q <= 1'b0;
              state_q <= H_IDLE;
            end
          endcase
        end
        H_BIT: begin
          case (phase_q)
            2'h0: sdaOe_q <= !out_q[8];
            2'h1: sclOe_q <= 1'b0;
            2'h2: in_q <= {in_q[7:0], pinSync_q[0]};
            default: begin
              sclOe_q <= 1'b1;
              out_q <= {out_q[7:0], 1'b1};
              bitIdx_q <= 4'(bitIdx_q + 4'h1);
              if (bitIdx_q == irpa_pkg::LAST_BIT) begin
                sdaOe_q <= 1'b0;
                state_q <= H_IDLE;
              end
            end
          endcase
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign bus.mSclOe = sclOe_q;
  assign bus.mSdaOe = sdaOe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

// ---- verification/irpa_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module irpa_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic tSdaOe,
  input wire logic busActive,
  input wire logic regWrEn,
  input wire logic [7:0] regWrAddr,
  input wire logic [7:0] regPtr,
  input wire logic intClr,
  input wire logic [1:0] intClrPort
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Moving sda while scl is high would read as a start or stop on the wire
  AST_TGT_SCL_LOW: assert property ($changed(tSdaOe) |-> !scl)
    else $error("target moved sda while scl high");
  AST_ACK_HOLD: assert property ($rose(tSdaOe) |-> tSdaOe [*8])
    else $error("target low drive too short");
  AST_STOP_IDLE: assert property (scl && $rose(sda) |-> ##[1:8] !busActive)
    else $error("target not idle after stop");
  AST_IDLE_FREE: assert property (!busActive |-> !tSdaOe)
    else $error("idle target drives sda");
  AST_WR_ADDR: assert property (regWrEn |-> regWrAddr == regPtr)
    else $error("write address differs from pointer");
  AST_WR_ONE: assert property (regWrEn |=> !regWrEn)
    else $error("write strobe longer than one cycle");
  AST_WR_BUSY: assert property (regWrEn |-> busActive)
    else $error("write strobe outside a transfer");
  AST_CLR_ONE: assert property (intClr |-> intClrPort <= 2'h2 ##1 !intClr)
    else $error("bad interrupt clear pulse");
  AST_PTR_RST: assert property ($fell(rst) |-> regPtr == 8'h00 && !busActive)
    else $error("target state not reset");
  cover property (regWrEn && regWrAddr == 8'h5C);
  cover property (intClr);
  cover property ($rose(tSdaOe));
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [4:0] OP_START = 5'(1 << irpa_pkg::CMD_START);
  localparam logic [4:0] OP_STOP = 5'(1 << irpa_pkg::CMD_STOP);
  localparam logic [7:0] AW = {irpa_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {irpa_pkg::DEV_ADDR, 1'b1};
  logic sys_clk, rst, resetPinN, psel, penable, pwrite, pready, pslverr, slvErr;
  logic regWrEn, intClr, busActive;
  logic [7:0] paddr, regPtr, regWrAddr, regWrData, regRdData;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] intClrPort;
  logic [7:0] mem [256];
  logic [7:0] wlog [$];
  int err_count, checked, cyc, clrs;
  irpa_if link();
  irpa_master irpa_master_inst (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(link.master));
  irpa_target irpa_target_inst (.sys_clk(sys_clk), .rst(rst), .resetPinN(resetPinN),
    .bus(link.target), .regRdData(regRdData), .regPtr(regPtr), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .intClr(intClr),
    .intClrPort(intClrPort), .busActive(busActive));
  irpa_props irpa_props_inst (.sys_clk(sys_clk), .rst(rst), .scl(link.scl), .sda(link.sda),
    .tSdaOe(link.tSdaOe), .busActive(busActive), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
    .regPtr(regPtr), .intClr(intClr), .intClrPort(intClrPort));
  // Register file stands in for the expander contents behind the pointer
  assign regRdData = mem[regPtr];
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (regWrEn === 1'b1) begin
      mem[regWrAddr] <= regWrData;
      wlog.push_back(regWrAddr);
    end
    if (intClr === 1'b1) clrs <= clrs + 1;
  end
  // 31 byte slots of 1800 cycles each fit well below this ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Only the cycle ceiling ends a wait for pready or for the engine
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Engine accepts a new command only when idle, so every command polls busy
  task automatic op(input logic [4:0] c);
    apb(1'b1, irpa_pkg::CMD_OFS, 32'(c));
    rd = 32'h1;
    while (rd[irpa_pkg::ST_BUSY] !== 1'b0) begin
      apb(1'b0, irpa_pkg::STATUS_OFS, 32'h0);
    end
  endtask
  task automatic tx(input logic [7:0] b, input logic nack);
    apb(1'b1, irpa_pkg::TXDATA_OFS, {24'h0, b});
    op(5'(1 << irpa_pkg::CMD_WRITE));
    chk("ack bit", 8'(nack), 8'(rd[irpa_pkg::ST_NACK]));
  endtask
  task automatic rx(input logic last, input logic [7:0] exp);
    op(5'(1 << irpa_pkg::CMD_READ) | (5'(last) << irpa_pkg::CMD_NACK));
    apb(1'b0, irpa_pkg::RXDATA_OFS, 32'h0);
    chk("read byte", exp, rd[7:0]);
  endtask
  task automatic wr(input logic [7:0] c, input int n);
    op(OP_START);
    tx(AW, 1'b0);
    tx(c, 1'b0);
    for (int i = 0; i < n; i++) tx(8'hA0 + 8'(i), 1'b0);
    op(OP_STOP);
  endtask
  task automatic expw(input logic [7:0] a);
    chk("write address", a, wlog.pop_front());
  endtask
  initial begin
    rst = 1'b1;
    resetPinN = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    checked = 0;
    cyc = 0;
    clrs = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, irpa_pkg::STATUS_OFS, 32'h0);
    chk("status", 8'h00, rd[7:0]);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 8'h01, 8'(slvErr));
    apb(1'b1, irpa_pkg::TXDATA_OFS, 32'h0000_00C3);
    apb(1'b0, irpa_pkg::TXDATA_OFS, 32'h0);
    chk("txdata", 8'hC3, rd[7:0]);
    $display("test registers done");
    wr(irpa_pkg::OUTPUT_LEVEL_1, 4);
    expw(8'h05);
    expw(8'h06);
    expw(8'h04);
    expw(8'h05);
    chk("reg 05", 8'hA3, mem[5]);
    wr(irpa_pkg::DRIVE_GROUP_BASE + 8'h05, 2);
    expw(8'h45);
    expw(8'h40);
    wr(irpa_pkg::EDGE_GROUP_BASE + 8'h05, 2);
    expw(8'h65);
    expw(8'h60);
    wr(irpa_pkg::OUTPUT_STAGE_TYPE, 2);
    expw(8'h5C);
    expw(8'h5C);
    $display("test writes done");
    op(OP_START);
    tx(AW, 1'b0);
    tx(irpa_pkg::OUTPUT_LEVEL_1, 1'b0);
    op(OP_START);
    chk("owns bus", 8'h01, 8'(rd[irpa_pkg::ST_OWNS]));
    tx(AR, 1'b0);
    rx(1'b0, 8'hA3);
    rx(1'b1, 8'hA1);
    op(OP_STOP);
    op(OP_START);
    tx(AR, 1'b0);
    rx(1'b1, 8'hA2);
    op(OP_STOP);
    chk("bus released", 8'h00, 8'(rd[irpa_pkg::ST_OWNS]));
    chk("writes during reads", 8'h00, 8'(wlog.size()));
    $display("test reads done");
    op(OP_START);
    tx(AW, 1'b0);
    tx(8'h00, 1'b0);
    op(OP_START);
    tx(AR, 1'b0);
    rx(1'b0, 8'h5A);
    rx(1'b1, 8'h5B);
    op(OP_STOP);
    chk("clear pulses", 8'h02, 8'(clrs));
    chk("clear port", 8'h01, 8'(intClrPort));
    // Pointer now rests on 02, so the pin reset below has something to undo
    $display("test input read done");
    op(OP_START);
    tx({irpa_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    op(OP_STOP);
    chk("busy after foreign address", 8'h00, 8'(busActive));
    resetPinN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("pointer after pin reset", 8'h00, regPtr);
    resetPinN <= 1'b1;
    repeat (6) @(posedge sys_clk);
    $display("test address and reset done");
    complete_run();
  end
endmodule
`default_nettype wire
